// >>> src/shc_codec.sv
// Purpose: Pack and unpack the destination, tag and source header groups.
// Assumes: Requests come from logic on clk; one result per request, 1 cycle later.
// Notes:   Functional notes
//
// Functional notes
// [RQ1] Bits 46:44 select forward kind; codes 0..6 defined, 7 reserved.
// [RQ2] Local lookup or global mirror: bits 42:32 carry eleven-bit rewrite command.
// [RQ3] Logical port kind: bit 42 is destination port type, 1 internal.
// [RQ4] Logical, physical, one-unit CPU: bits 41:37 give destination unit.
// [RQ5] Logical port kind: bits 36:32 give logical destination port.
// [RQ6] Physical port kind: bit 42 zero, bits 36:32 physical port.
// [RQ7] Group kind: bit 42 zero, bits 41:32 ten-bit group index.
// [RQ8] One-unit CPU: bits 42 and 36 zero, bits 35:32 CPU port.
// [RQ9] Every-unit CPU: bit 41 keeps TTL, bits 42 and 40:36 zero.
// [RQ10] Sender drives every reserved destination position to zero.
// [RQ11] Priority code 31:29, drop eligible 28, VLAN id 27:16.
// [RQ12] Bit 15 set when frame arrived tagged.
// [RQ13] Bit 14: zero customer tag 0x8100, one service tag 0x88A8.
// [RQ14] Bits 13:12 port class: 00 promiscuous, 01 community, 10 isolated.
// [RQ15] Bit 10 source addressing: zero individual port, one aggregation group.
// [RQ16] Bit 11 individual: 0 unit port, 1 internal; group: zero.
// [RQ17] Individual source: bits 9:5 give source unit.
// [RQ18] Individual unit-port source: bits 4:0 give logical source port.
// [RQ19] Individual internal source: bits 3:0 give internal port number.
// [RQ20] Group source: five-bit aggregation group identifier in lowest bits.
// [RQ21] Parser decodes by forward kind, ignores reserved; packer zeroes undefined bits.
`timescale 1ns/100ps

module shc_codec
   import shc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             packReq,
   input  wire shc_fields_t      packFields,
   input  wire logic             parseReq,
   input  wire logic [HDR_W-1:0] parseHdr,
   output logic                  packValid,
   output logic [HDR_W-1:0]      packHdr,
   output logic                  parseValid,
   output shc_fields_t           parseFields,
   output logic                  parseBadKind
);

   //------------------------------------------------------------
   // Reset release
   //------------------------------------------------------------
   logic rstSync1_r;
   logic rstSync2_r;

   // Async assert, clocked release so all state leaves reset together
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync1_r <= 1'b0;
         rstSync2_r <= 1'b0;
      end else begin
         rstSync1_r <= 1'b1;
         rstSync2_r <= rstSync1_r;
      end
   end

   //------------------------------------------------------------
   // Packing function
   //------------------------------------------------------------
   // Starts from zero so every position the kind leaves undefined stays zero
   function automatic logic [HDR_W-1:0] pack_hdr(input shc_fields_t f);
      logic [HDR_W-1:0] h;
      h = HDR_RST;
      h[FWD_LSB +: 3] = f.forwardKind;                               // [RQ1]
      case (f.forwardKind)
         fwd_local_lookup, fwd_global_mirror: begin
            h[PORT_LSB +: 11] = f.rewriteCommand;                   // [RQ2]
         end
         port_a: begin
            h[DST_B42]         = f.destInternal;                    // [RQ3]
            h[UNIT_LSB +: 5]   = f.destUnit;                        // [RQ4]
            h[PORT_LSB +: 5]   = f.destPortNumber;                  // [RQ5]
         end
         fwd_port_b: begin
            h[UNIT_LSB +: 5]   = f.destUnit;                        // [RQ4]
            h[PORT_LSB +: 5]   = f.destPortNumber;                  // [RQ6]
         end
         fwd_group: begin
            h[PORT_LSB +: 10]  = f.groupIndex;                      // [RQ7]
         end
         fwd_cpu_one_unit: begin
            h[UNIT_LSB +: 5]   = f.destUnit;                        // [RQ4]
            h[PORT_LSB +: 4]   = f.destPortNumber[3:0];             // [RQ8]
         end
         fwd_cpu_every_unit: begin
            h[TTLK_BIT]        = f.ttlKeep;                         // [RQ9]
            h[PORT_LSB +: 4]   = f.destPortNumber[3:0];             // [RQ9]
         end
         default: begin
            h[PORT_LSB +: 11]  = 11'h000;                           // [RQ21]
         end
      endcase
      h[PCP_LSB +: 3]  = f.classifiedPriorityCode;                  // [RQ11]
      h[DEI_BIT]       = f.classifiedDropEligible;                  // [RQ11]
      h[VID_LSB +: 12] = f.classifiedVlanId;                        // [RQ11]
      h[TAGD_BIT]      = f.wasTagged;                               // [RQ12]
      h[TTYP_BIT]      = f.serviceTag;                              // [RQ13]
      h[IPC_LSB +: 2]  = f.ingressPortClass;                        // [RQ14]
      h[SAM_BIT]       = f.srcIsGroup;                              // [RQ15]
      if (f.srcIsGroup) begin
         h[4:0] = f.sourceAggregationGroup;                         // [RQ20]
      end else begin
         h[SPT_BIT]          = f.srcInternal;                       // [RQ16]
         h[SUNIT_LSB +: 5]   = f.srcUnit;                           // [RQ17]
         if (f.srcInternal) begin
            h[3:0] = f.srcPort[3:0];                                // [RQ19]
         end else begin
            h[4:0] = f.srcPort;                                     // [RQ18]
         end
      end
      return h;
   endfunction : pack_hdr

   //------------------------------------------------------------
   // Parsing function
   //------------------------------------------------------------
   // Fields not defined for the received kind come out as zero
   function automatic shc_fields_t parse_hdr(input logic [HDR_W-1:0] h);
      shc_fields_t f;
      f = '0;
      f.forwardKind = shc_fwd_t'(h[FWD_LSB +: 3]);                 // [RQ1]
      case (shc_fwd_t'(h[FWD_LSB +: 3]))
         fwd_local_lookup, fwd_global_mirror: begin
            f.rewriteCommand = h[PORT_LSB +: 11];                   // [RQ2]
         end
         port_a: begin
            f.destInternal   = h[DST_B42];                          // [RQ3]
            f.destUnit       = h[UNIT_LSB +: 5];                    // [RQ4]
            f.destPortNumber = h[PORT_LSB +: 5];                    // [RQ5]
         end
         fwd_port_b: begin
            f.destUnit       = h[UNIT_LSB +: 5];                    // [RQ4]
            f.destPortNumber = h[PORT_LSB +: 5];                    // [RQ6]
         end
         fwd_group: begin
            f.groupIndex     = h[PORT_LSB +: 10];                   // [RQ7]
         end
         fwd_cpu_one_unit: begin
            f.destUnit       = h[UNIT_LSB +: 5];                    // [RQ4]
            f.destPortNumber = {1'b0, h[PORT_LSB +: 4]};            // [RQ8]
         end
         fwd_cpu_every_unit: begin
            f.ttlKeep        = h[TTLK_BIT];                         // [RQ9]
            f.destPortNumber = {1'b0, h[PORT_LSB +: 4]};            // [RQ21]
         end
         default: begin
            f.rewriteCommand = 11'h000;                             // [RQ21]
         end
      endcase
      f.classifiedPriorityCode = h[PCP_LSB +: 3];                   // [RQ11]
      f.classifiedDropEligible = h[DEI_BIT];                        // [RQ11]
      f.classifiedVlanId       = h[VID_LSB +: 12];                  // [RQ11]
      f.wasTagged              = h[TAGD_BIT];                       // [RQ12]
      f.serviceTag             = h[TTYP_BIT];                       // [RQ13]
      f.ingressPortClass       = h[IPC_LSB +: 2];                   // [RQ14]
      f.srcIsGroup             = h[SAM_BIT];                        // [RQ15]
      if (h[SAM_BIT]) begin
         f.sourceAggregationGroup = h[4:0];                         // [RQ20]
      end else begin
         f.srcInternal = h[SPT_BIT];                                // [RQ16]
         f.srcUnit     = h[SUNIT_LSB +: 5];                         // [RQ17]
         f.srcPort     = h[SPT_BIT] ? {1'b0, h[3:0]} : h[4:0];      // [RQ18] [RQ19]
      end
      return f;
   endfunction : parse_hdr

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   shc_state_t state_r;
   shc_state_t state_nxt;

   // Results hold until the next request so a slow consumer still sees them
   always_comb begin
      state_nxt            = state_r;
      state_nxt.packValid  = packReq;
      state_nxt.parseValid = parseReq;
      if (packReq) begin
         state_nxt.packHdr = pack_hdr(packFields);
      end
      if (parseReq) begin
         state_nxt.parseFields  = parse_hdr(parseHdr);
         state_nxt.parseBadKind = (parseHdr[FWD_LSB +: 3] == fwd_reserved); // [RQ1]
      end
   end

   // Single state register
   always_ff @(posedge clk or negedge rstSync2_r) begin
      if (!rstSync2_r) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign packValid    = state_r.packValid;
   assign packHdr      = state_r.packHdr;
   assign parseValid   = state_r.parseValid;
   assign parseFields  = state_r.parseFields;
   assign parseBadKind = state_r.parseBadKind;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   a_pack_kind: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ1]
      packReq |=> packHdr[FWD_LSB +: 3] == $past(packFields.forwardKind))
      else $error("forward kind not packed");
   a_pack_rewrite: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ2]
      packReq && (packFields.forwardKind == fwd_global_mirror
                  || packFields.forwardKind == fwd_local_lookup)
      |=> packHdr[42:32] == $past(packFields.rewriteCommand))
      else $error("rewrite command misplaced");
   a_pack_logical: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ5]
      packReq && packFields.forwardKind == port_a
      |=> packHdr[36:32] == $past(packFields.destPortNumber)
          && packHdr[42] == $past(packFields.destInternal))
      else $error("logical destination wrong");
   a_pack_phys_zero: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ6]
      packReq && packFields.forwardKind == fwd_port_b |=> packHdr[42] == 1'b0)
      else $error("physical bit 42 not zero");
   a_pack_group: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ7]
      packReq && packFields.forwardKind == fwd_group
      |=> packHdr[41:32] == $past(packFields.groupIndex) && !packHdr[42])
      else $error("group index wrong");
   a_pack_cpu_one: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ8]
      packReq && packFields.forwardKind == fwd_cpu_one_unit
      |=> !packHdr[42] && !packHdr[36] && packHdr[41:37] == $past(packFields.destUnit))
      else $error("one-unit cpu layout wrong");
   a_pack_cpu_all: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ9]
      packReq && packFields.forwardKind == fwd_cpu_every_unit
      |=> packHdr[40:36] == 5'h0 && !packHdr[42] && packHdr[41] == $past(packFields.ttlKeep))
      else $error("every-unit cpu layout wrong");
   a_pack_tag: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ11]
      packReq |=> packHdr[27:16] == $past(packFields.classifiedVlanId)
                  && packHdr[15] == $past(packFields.wasTagged))
      else $error("tag group wrong");
   a_pack_glag: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ16]
      packReq && packFields.srcIsGroup
      |=> packHdr[10] && !packHdr[11] && packHdr[4:0] == $past(packFields.sourceAggregationGroup))
      else $error("group source wrong");
   a_parse_round: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ21]
      parseReq && parseHdr[46:44] == 3'h3
      |=> parseFields.groupIndex == $past(parseHdr[41:32]) && parseFields.destUnit == 5'h0)
      else $error("parse not by kind");
   a_parse_hold: assert property (@(posedge clk) disable iff (!rstSync2_r) // [RQ17]
      parseValid && !parseReq |=> $stable(parseFields))
      else $error("parse result not held");

   c_pack_logical: cover property (@(posedge clk) disable iff (!rstSync2_r)
      packReq && packFields.forwardKind == port_a);
   c_parse_group: cover property (@(posedge clk) disable iff (!rstSync2_r)
      parseReq && parseHdr[10]);
   c_parse_bad: cover property (@(posedge clk) disable iff (!rstSync2_r) parseBadKind);
   c_back_to_back: cover property (@(posedge clk) disable iff (!rstSync2_r)
      packReq ##1 packReq);

endmodule : shc_codec

// >>> src/shc_pkg.sv
// Purpose: Shared constants and field carriers for the stack header field codec.
// Assumes: Header bits 46:0 are handled; upper fields live elsewhere.
// Notes:   Field positions are given as low bit only; widths are written at each use.
package shc_pkg;

   //------------------------------------------------------------
   // Widths
   //------------------------------------------------------------
   localparam int HDR_W = 47;

   //------------------------------------------------------------
   // Field positions
   //------------------------------------------------------------
   localparam int FWD_LSB   = 44;
   localparam int DST_B42   = 42;
   localparam int UNIT_LSB  = 37;
   localparam int DST_B36   = 36;
   localparam int PORT_LSB  = 32;
   localparam int TTLK_BIT  = 41;
   localparam int PCP_LSB   = 29;
   localparam int DEI_BIT   = 28;
   localparam int VID_LSB   = 16;
   localparam int TAGD_BIT  = 15;
   localparam int TTYP_BIT  = 14;
   localparam int IPC_LSB   = 12;
   localparam int SPT_BIT   = 11;
   localparam int SAM_BIT   = 10;
   localparam int SUNIT_LSB = 5;

   //------------------------------------------------------------
   // Reset values
   //------------------------------------------------------------
   localparam logic [HDR_W-1:0] HDR_RST = 47'h0000_0000_0000;

   //------------------------------------------------------------
   // Forward kinds
   //------------------------------------------------------------
   typedef enum logic [2:0] {
      fwd_local_lookup   = 3'h0,
      port_a             = 3'h1,
      fwd_port_b         = 3'h2,
      fwd_group          = 3'h3,
      fwd_global_mirror  = 3'h4,
      fwd_cpu_one_unit   = 3'h5,
      fwd_cpu_every_unit = 3'h6,
      fwd_reserved       = 3'h7
   } shc_fwd_t;

   // Ingress port class codes
   localparam logic [1:0] IPC_PROMISC   = 2'h0;
   localparam logic [1:0] IPC_COMMUNITY = 2'h1;
   localparam logic [1:0] IPC_ISOLATED  = 2'h2;

   //------------------------------------------------------------
   // Carriers
   //------------------------------------------------------------
   typedef struct packed {
      shc_fwd_t    forwardKind;
      logic [10:0] rewriteCommand;
      logic        destInternal;
      logic [4:0]  destUnit;
      logic [4:0]  destPortNumber;
      logic [9:0]  groupIndex;
      logic        ttlKeep;
      logic [2:0]  classifiedPriorityCode;
      logic        classifiedDropEligible;
      logic [11:0] classifiedVlanId;
      logic        wasTagged;
      logic        serviceTag;
      logic [1:0]  ingressPortClass;
      logic        srcIsGroup;
      logic        srcInternal;
      logic [4:0]  srcUnit;
      logic [4:0]  srcPort;
      logic [4:0]  sourceAggregationGroup;
   } shc_fields_t;

   typedef struct packed {
      logic             packValid;
      logic [HDR_W-1:0] packHdr;
      logic             parseValid;
      shc_fields_t      parseFields;
      logic             parseBadKind;
   } shc_state_t;

endpackage : shc_pkg

// >>> tb/shc_far_unit.sv
// Purpose: Model of the neighbouring stack unit that sends and receives headers.
// Assumes: Combinational; the bench samples it between clock edges.
// Notes:   Sends reserved positions as zero and ignores them on receive.
`timescale 1ns/100ps

module shc_far_unit
   import shc_pkg::*;
(
   input  wire shc_fields_t      txF,
   output logic [HDR_W-1:0]      txHdr,
   input  wire logic [HDR_W-1:0] rxHdr,
   output shc_fields_t           rxF
);
   //------------------------------------------------------------
   // Sender side
   //------------------------------------------------------------
   // Start from zero so every undefined position leaves as zero
   always_comb begin : send_p
      txHdr = '0;
      txHdr[46:44] = txF.forwardKind;
      case (txF.forwardKind)
         fwd_local_lookup, fwd_global_mirror: txHdr[42:32] = txF.rewriteCommand;
         port_a: txHdr[42:32] =
            {txF.destInternal, txF.destUnit, txF.destPortNumber};
         fwd_port_b: txHdr[41:32] = {txF.destUnit, txF.destPortNumber};
         fwd_group: txHdr[41:32] = txF.groupIndex;
         fwd_cpu_one_unit: {txHdr[41:37], txHdr[35:32]} =
            {txF.destUnit, txF.destPortNumber[3:0]};
         fwd_cpu_every_unit: {txHdr[41], txHdr[35:32]} =
            {txF.ttlKeep, txF.destPortNumber[3:0]};
         default: ;
      endcase
      txHdr[31:12] = {txF.classifiedPriorityCode, txF.classifiedDropEligible,
                      txF.classifiedVlanId, txF.wasTagged, txF.serviceTag,
                      txF.ingressPortClass};
      txHdr[10] = txF.srcIsGroup;
      if (txF.srcIsGroup) begin
         txHdr[4:0] = txF.sourceAggregationGroup;
      end else begin
         txHdr[11] = txF.srcInternal;
         txHdr[9:5] = txF.srcUnit;
         txHdr[4:0] = txF.srcInternal ? {1'b0, txF.srcPort[3:0]} : txF.srcPort;
      end
   end

   //------------------------------------------------------------
   // Receiver side
   //------------------------------------------------------------
   // Decode only what the kind defines; reserved bits never leak through
   always_comb begin : recv_p
      rxF = '0;
      rxF.forwardKind = shc_fwd_t'(rxHdr[46:44]);
      case (rxF.forwardKind)
         fwd_local_lookup, fwd_global_mirror: rxF.rewriteCommand = rxHdr[42:32];
         port_a: {rxF.destInternal, rxF.destUnit, rxF.destPortNumber} =
            rxHdr[42:32];
         fwd_port_b: {rxF.destUnit, rxF.destPortNumber} = rxHdr[41:32];
         fwd_group: rxF.groupIndex = rxHdr[41:32];
         fwd_cpu_one_unit: {rxF.destUnit, rxF.destPortNumber} =
            {rxHdr[41:37], 1'b0, rxHdr[35:32]};
         fwd_cpu_every_unit: {rxF.ttlKeep, rxF.destPortNumber} =
            {rxHdr[41], 1'b0, rxHdr[35:32]};
         default: ;
      endcase
      {rxF.classifiedPriorityCode, rxF.classifiedDropEligible, rxF.classifiedVlanId, rxF.wasTagged,
       rxF.serviceTag, rxF.ingressPortClass} = rxHdr[31:12];
      rxF.srcIsGroup = rxHdr[10];
      if (rxHdr[10]) begin
         rxF.sourceAggregationGroup = rxHdr[4:0];
      end else begin
         rxF.srcInternal = rxHdr[11];
         rxF.srcUnit = rxHdr[9:5];
         rxF.srcPort = rxHdr[11] ? {1'b0, rxHdr[3:0]} : rxHdr[4:0];
      end
   end
endmodule : shc_far_unit

// >>> tb/stack_header_field_codec_test.sv
// Purpose: Self-checking bench for the header codec against the far unit model.
// Assumes: Inputs change at the falling edge; results read one cycle later, at the next falling edge.
// Notes:   Every row is issued back to back on both paths at once.
`timescale 1ns/100ps

module stack_header_field_codec_test;
   import shc_pkg::*;
   logic             clk, arst_n, packReq, parseReq, packValid, parseValid, parseBadKind, pend, expBad;
   shc_fields_t      packFields, parseFields, farTx, farRx, expRx;
   logic [HDR_W-1:0] parseHdr, packHdr, farHdr, expHdr;
   shc_fields_t      rows [16];
   int               failures, compares;

   shc_codec u_dut (.clk(clk), .arst_n(arst_n), .packReq(packReq), .packFields(packFields),
      .parseReq(parseReq), .parseHdr(parseHdr), .packValid(packValid), .packHdr(packHdr),
      .parseValid(parseValid), .parseFields(parseFields), .parseBadKind(parseBadKind));
   shc_far_unit u_far (.txF(farTx), .txHdr(farHdr), .rxHdr(parseHdr), .rxF(farRx));

   //------------------------------------------------------------
   // Clock and shared tasks
   //------------------------------------------------------------
   initial begin : clk_p
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [127:0] seen, input logic [127:0] want, input string what);
      compares++;
      if (seen !== want) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : check

   task automatic wrap_up();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // Checks the previous cycle's answer, then issues the next request;
   // flip corrupts reserved bits of the parsed header only
   task automatic step(input shc_fields_t f, input logic [HDR_W-1:0] flip, input logic req);
      @(negedge clk);
      check(packValid, pend, "pack valid");
      check(parseValid, pend, "parse valid");
      check(packHdr, expHdr, "packed header");
      check(parseFields, expRx, "parsed fields");
      check(parseBadKind, expBad, "bad kind flag");
      pend = req;
      packReq = req;
      parseReq = req;
      if (req) begin
         farTx = f;
         packFields = f;
         #0.1 parseHdr = farHdr ^ flip;
         #0.1 expHdr = farHdr;
         expRx = farRx;
         expBad = (parseHdr[46:44] == 3'h7);
      end
   endtask : step

   task automatic clear_exp();
      pend = 1'b0;
      expHdr = '0;
      expRx = '0;
      expBad = 1'b0;
   endtask : clear_exp

   //------------------------------------------------------------
   // Watchdog: the whole run needs well under 500 cycles
   //------------------------------------------------------------
   initial begin : dog_p
      #(4 * 5000);
      failures++;
      wrap_up();
   end

   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin : main_p
      {arst_n, packReq, parseReq, failures, compares} = '0;
      packFields = '0;
      farTx = '0;
      parseHdr = '0;
      clear_exp();
      // Rows cover all eight kinds twice, every port class and source mode
      for (int i = 0; i < 16; i++) begin
         rows[i] = '0;
         rows[i].forwardKind = shc_fwd_t'(i % 8);
         rows[i].rewriteCommand = 11'(11'h5A5 ^ (i * 37));
         rows[i].destInternal = i[1] ^ i[0];
         rows[i].destUnit = 5'(5'h15 ^ i);
         rows[i].destPortNumber = 5'(5'h1B ^ (i * 3));
         rows[i].groupIndex = 10'(10'h2D6 ^ (i * 41));
         rows[i].ttlKeep = i[3];
         rows[i].classifiedPriorityCode = 3'(i);
         rows[i].classifiedDropEligible = i[1];
         rows[i].classifiedVlanId = 12'(12'hA5C ^ (i * 97));
         rows[i].wasTagged = i[0];
         rows[i].serviceTag = i[2];
         rows[i].ingressPortClass = 2'(i % 3);
         rows[i].srcIsGroup = (i % 3 == 2);
         rows[i].srcInternal = (i % 3 == 1);
         rows[i].srcUnit = 5'(5'h13 ^ i);
         rows[i].srcPort = 5'(5'h1E ^ i);
         rows[i].sourceAggregationGroup = 5'(5'h0B ^ i);
      end
      // Outputs are zero in reset and for two edges after release
      repeat (10) step(rows[0], '0, 1'b0);
      arst_n = 1'b1;
      repeat (2) step(rows[0], '0, 1'b0);
      // Back-to-back rows, then one idle cycle to see the results hold
      for (int i = 0; i < 16; i++) step(rows[i], '0, 1'b1);
      step(rows[0], '0, 1'b0);
      // Reserved positions set on receive must be ignored
      step(rows[7], 47'h0FFF_0000_0000, 1'b1);
      step(rows[5], 47'h0C10_0000_0000, 1'b1);
      step(rows[6], 47'h0DF0_0000_0000, 1'b1);
      step(rows[2], 47'h0C00_0000_0BE0, 1'b1);
      step(rows[3], 47'h0C00_0000_0000, 1'b1);
      step(rows[4], 47'h0800_0000_0010, 1'b1);
      step(rows[0], '0, 1'b0);
      // Reset in mid-run clears everything at once
      step(rows[9], '0, 1'b1);
      // Row 9 is checked and requests dropped before reset falls on them
      step(rows[0], '0, 1'b0);
      arst_n = 1'b0;
      #1;
      check(packHdr, '0, "pack header after reset");
      check(parseFields, '0, "parse fields after reset");
      check(packValid | parseValid | parseBadKind, 1'b0, "flags after reset");
      clear_exp();
      step(rows[0], '0, 1'b0);
      arst_n = 1'b1;
      repeat (2) step(rows[0], '0, 1'b0);
      step(rows[10], '0, 1'b1);
      step(rows[0], '0, 1'b0);
      step(rows[0], '0, 1'b0);
      wrap_up();
   end
endmodule : stack_header_field_codec_test
